// ### verilog/sac_cache.sv
// sac_cache: set-associative cache lookup with self-modifying code detection
// assumes the pipeline presents one physical-address access at a time and holds it on miss;
// fill data arrives from the memory side as a whole line; all inputs share CLK_SYS
// Function
// (RULE_01) storage is sets of lines, one line per way in each set
// (RULE_02) lookup uses the physical address only
// (RULE_03) index field selects one set; all its ways are examined
// (RULE_04) tag compared against each way; match gives hit and selects way
// (RULE_05) no tag match in the set signals a miss
// (RULE_06) hit reads or writes the line starting at the offset byte
// (RULE_07) each line keeps MOESI state and replacement bits; here replacement bits are one rr_q pointer per set, not per line
// (RULE_08) a store hitting an instruction-cache line invalidates it automatically
// (RULE_09) store hitting in-flight instruction bytes flushes pipeline and restarts fetch
// (RULE_10) in-flight overlap is found by comparing physical addresses
// (RULE_11) data line may stay shared; instruction refill served coherently
// (RULE_12) stores become visible to the fetcher in program order
// (RULE_13) fetcher reads sequential addresses between taken branches
// (RULE_14) a quadword store is applied atomically in one cycle
// (RULE_15) split instruction yields only the new instructions, never mixed bytes
// (RULE_16) uncoordinated cross-modification uses one store inside an aligned quadword
// (RULE_17) released target thread runs a serializing instruction before modified code
// (RULE_18) on cacheable miss pick victim from replacement state, fill, update tag
`timescale 1ns/10ps
module sac_cache (
	input  wire logic                      CLK_SYS,
	input  wire logic                      RST,
	input  wire logic                      REQ_VALID,
	input  wire logic                      REQ_WRITE,
	input  wire logic                      REQ_CACHEABLE,
	input  wire logic [sac_pkg::PA_W-1:0]  REQ_PADDR,
	input  wire logic [sac_pkg::QW_W-1:0]  REQ_WDATA,
	input  wire logic                      FILL_VALID,
	input  wire logic [sac_pkg::LINE_W-1:0] FILL_DATA,
	input  wire logic                      INFL_VALID_0,
	input  wire logic [sac_pkg::PA_W-1:0]  INFL_PADDR_0,
	input  wire logic                      INFL_VALID_1,
	input  wire logic [sac_pkg::PA_W-1:0]  INFL_PADDR_1,
	input  wire logic                      INFL_VALID_2,
	input  wire logic [sac_pkg::PA_W-1:0]  INFL_PADDR_2,
	input  wire logic                      INFL_VALID_3,
	input  wire logic [sac_pkg::PA_W-1:0]  INFL_PADDR_3,
	input  wire logic                      FETCH_VALID,
	input  wire logic                      FETCH_BRANCH,
	input  wire logic [sac_pkg::PA_W-1:0]  FETCH_PADDR,
	output logic                           RSP_VALID,
	output logic                           RSP_HIT,
	output logic                           RSP_MISS,
	output logic [sac_pkg::QW_W-1:0]       RSP_RDATA,
	output logic [sac_pkg::WAY_W-1:0]      RSP_WAY,
	output logic                           FILL_REQ,
	output logic [sac_pkg::PA_W-1:0]       FILL_PADDR,
	output logic                           ICACHE_INV,
	output logic [sac_pkg::PA_W-1:0]       ICACHE_INV_PADDR,
	output logic                           PIPE_FLUSH,
	output logic [sac_pkg::PA_W-1:0]       FETCH_RESTART_PADDR,
	output logic                           FETCH_SEQ_ERR
);
	localparam int W      = sac_pkg::WAYS;
	localparam int INFL   = sac_pkg::INFL;
	localparam int QW_W   = sac_pkg::QW_W;
	localparam int LINE_W = sac_pkg::LINE_W;

	function automatic logic [sac_pkg::IDX_W-1:0] idx_of(input logic [sac_pkg::PA_W-1:0] a);
		idx_of = a[sac_pkg::IDX_LSB +: sac_pkg::IDX_W]; // [RULE_02] [RULE_03]
	endfunction
	function automatic logic [sac_pkg::TAG_W-1:0] tag_of(input logic [sac_pkg::PA_W-1:0] a);
		tag_of = a[sac_pkg::TAG_LSB +: sac_pkg::TAG_W];
	endfunction
	// physical quadword match, so two virtual aliases of one byte still collide
	function automatic logic qw_same(input logic [sac_pkg::PA_W-1:0] a,
		input logic [sac_pkg::PA_W-1:0] b);
		qw_same = a[sac_pkg::PA_W-1:3] == b[sac_pkg::PA_W-1:3]; // [RULE_10]
	endfunction

	// arrays: one line per way in every set
	logic [sac_pkg::LINE_W-1:0] data_q [sac_pkg::SETS][W]; // [RULE_01]
	logic [sac_pkg::TAG_W-1:0]  tag_q  [sac_pkg::SETS][W];
	sac_pkg::sac_moesi_t        st_q   [sac_pkg::SETS][W]; // [RULE_07]
	logic [1:0]                 rr_q   [sac_pkg::SETS];    // [RULE_07]
	logic [sac_pkg::LINE_W-1:0] data_d [sac_pkg::SETS][W];
	logic [sac_pkg::TAG_W-1:0]  tag_d  [sac_pkg::SETS][W];
	sac_pkg::sac_moesi_t        st_d   [sac_pkg::SETS][W];
	logic [1:0]                 rr_d   [sac_pkg::SETS];

	sac_pkg::sac_state_t        fsm_q, fsm_d;
	logic [sac_pkg::PA_W-1:0]   miss_pa_q, miss_pa_d;
	logic [sac_pkg::PA_W-1:0]   fetch_last_q, fetch_last_d;
	logic                       fetch_seen_q, fetch_seen_d;

	logic                       rsp_valid_q, rsp_valid_d, rsp_hit_q, rsp_hit_d;
	logic                       rsp_miss_q, rsp_miss_d, fill_req_q, fill_req_d;
	logic [sac_pkg::QW_W-1:0]   rsp_rdata_q, rsp_rdata_d;
	logic [sac_pkg::WAY_W-1:0]  rsp_way_q, rsp_way_d;
	logic                       inv_q, inv_d, flush_q, flush_d, seq_err_q, seq_err_d;
	logic [sac_pkg::PA_W-1:0]   inv_pa_q, inv_pa_d, restart_q, restart_d;

	logic [sac_pkg::IDX_W-1:0]  idx;
	logic [sac_pkg::TAG_W-1:0]  tag;
	logic [sac_pkg::OFF_W-1:0]  off;
	logic [W-1:0]               way_hit;
	logic                       hit;
	logic [sac_pkg::WAY_W-1:0]  hit_way;
	logic [INFL-1:0]            infl_v;
	logic [sac_pkg::PA_W-1:0]   infl_pa [INFL];
	logic [INFL-1:0]            infl_hit;

	assign idx = idx_of(REQ_PADDR);
	assign tag = tag_of(REQ_PADDR);
	assign off = REQ_PADDR[sac_pkg::OFF_LSB +: sac_pkg::OFF_W];
	assign infl_v = {INFL_VALID_3, INFL_VALID_2, INFL_VALID_1, INFL_VALID_0};
	assign infl_pa[0] = INFL_PADDR_0;
	assign infl_pa[1] = INFL_PADDR_1;
	assign infl_pa[2] = INFL_PADDR_2;
	assign infl_pa[3] = INFL_PADDR_3;

	genvar gw;
	generate
		for (gw = 0; gw < W; gw++) begin : g_cmp
			// every way of the indexed set compared in parallel
			assign way_hit[gw] = (st_q[idx][gw] != sac_pkg::SAC_INV)
				&& (tag_q[idx][gw] == tag); // [RULE_03] [RULE_04]
		end
		for (gw = 0; gw < INFL; gw++) begin : g_infl
			assign infl_hit[gw] = infl_v[gw] && qw_same(infl_pa[gw], REQ_PADDR); // [RULE_10]
		end
	endgenerate

	always_comb begin
		hit = |way_hit; // [RULE_04] [RULE_05]
		hit_way = '0;
		for (int i = 0; i < W; i++) begin
			if (way_hit[i]) begin
				hit_way = sac_pkg::WAY_W'(i);
			end
		end
	end

	always_comb begin
		logic [sac_pkg::LINE_W-1:0] line;
		logic [sac_pkg::LINE_W-1:0] mask;
		logic [sac_pkg::IDX_W-1:0]  fidx;
		logic [sac_pkg::WAY_W-1:0]  vic;
		logic                       take;
		line = '0;
		mask = '0;
		fidx = idx_of(miss_pa_q);
		vic = rr_q[fidx];
		take = REQ_VALID && fsm_q == sac_pkg::SAC_IDLE;
		data_d = data_q;
		tag_d = tag_q;
		st_d = st_q;
		rr_d = rr_q;
		fsm_d = fsm_q;
		miss_pa_d = miss_pa_q;
		rsp_valid_d = 1'b0;
		rsp_hit_d = 1'b0;
		rsp_miss_d = 1'b0;
		rsp_rdata_d = rsp_rdata_q;
		rsp_way_d = rsp_way_q;
		fill_req_d = fill_req_q;
		inv_d = 1'b0;
		inv_pa_d = inv_pa_q;
		flush_d = 1'b0;
		restart_d = restart_q;
		unique case (fsm_q)
			sac_pkg::SAC_IDLE: begin
				if (take && hit) begin
					line = data_q[idx][hit_way];
					rsp_valid_d = 1'b1;
					rsp_hit_d = 1'b1;
					rsp_way_d = hit_way;
					// byte lane chosen by offset; bytes past the line end read as zero
					rsp_rdata_d = QW_W'(line >> {off, 3'h0}); // [RULE_06]
					rr_d[idx] = hit_way + 2'h1; // [RULE_07]
					if (REQ_WRITE) begin
						// quadword bytes inside the line land in one cycle, bytes past the line end are dropped; fetch sees old or new only
						mask = LINE_W'({QW_W{1'b1}}) << {off, 3'h0};
						line = (line & ~mask)
							| (LINE_W'(REQ_WDATA) << {off, 3'h0}); // [RULE_06] [RULE_14] [RULE_15]
						data_d[idx][hit_way] = line;
						st_d[idx][hit_way] = sac_pkg::SAC_MOD;
					end
				end else if (take) begin
					rsp_valid_d = 1'b1;
					rsp_miss_d = 1'b1; // [RULE_05]
					if (REQ_CACHEABLE) begin
						fsm_d = sac_pkg::SAC_FILL; // [RULE_18]
						miss_pa_d = REQ_PADDR;
						fill_req_d = 1'b1;
					end
				end
				if (take && REQ_WRITE) begin
					// invalidate issued in store order, one per taken store
					inv_d = 1'b1; // [RULE_08] [RULE_12]
					inv_pa_d = REQ_PADDR;
					if (|infl_hit) begin
						flush_d = 1'b1; // [RULE_09]
						restart_d = {REQ_PADDR[sac_pkg::PA_W-1:3], 3'h0};
					end
				end
			end
			sac_pkg::SAC_FILL: begin
				if (FILL_VALID) begin
					fill_req_d = 1'b0;
					data_d[fidx][vic] = FILL_DATA; // [RULE_18]
					tag_d[fidx][vic] = tag_of(miss_pa_q);
					// refill comes back shared so a code line can coexist in both caches
					st_d[fidx][vic] = sac_pkg::SAC_SHR; // [RULE_11]
					rr_d[fidx] = vic + 2'h1;
					fsm_d = sac_pkg::SAC_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		fetch_last_d = fetch_last_q;
		fetch_seen_d = fetch_seen_q;
		seq_err_d = 1'b0;
		if (FETCH_VALID) begin
			if (fetch_seen_q && !FETCH_BRANCH && FETCH_PADDR <= fetch_last_q) begin
				seq_err_d = 1'b1; // [RULE_13]
			end
			fetch_last_d = FETCH_PADDR;
			fetch_seen_d = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			for (int s = 0; s < sac_pkg::SETS; s++) begin
				rr_q[s] <= sac_pkg::RR_RST;
				for (int w = 0; w < W; w++) begin
					st_q[s][w] <= sac_pkg::SAC_INV;
					tag_q[s][w] <= '0;
					data_q[s][w] <= '0;
				end
			end
			fsm_q <= sac_pkg::SAC_IDLE;
			miss_pa_q <= '0;
			fetch_last_q <= '0;
			fetch_seen_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_hit_q <= 1'b0;
			rsp_miss_q <= 1'b0;
			rsp_rdata_q <= '0;
			rsp_way_q <= '0;
			fill_req_q <= 1'b0;
			inv_q <= 1'b0;
			inv_pa_q <= '0;
			flush_q <= 1'b0;
			restart_q <= '0;
			seq_err_q <= 1'b0;
		end else begin
			data_q <= data_d;
			tag_q <= tag_d;
			st_q <= st_d;
			rr_q <= rr_d;
			fsm_q <= fsm_d;
			miss_pa_q <= miss_pa_d;
			fetch_last_q <= fetch_last_d;
			fetch_seen_q <= fetch_seen_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_hit_q <= rsp_hit_d;
			rsp_miss_q <= rsp_miss_d;
			rsp_rdata_q <= rsp_rdata_d;
			rsp_way_q <= rsp_way_d;
			fill_req_q <= fill_req_d;
			inv_q <= inv_d;
			inv_pa_q <= inv_pa_d;
			flush_q <= flush_d;
			restart_q <= restart_d;
			seq_err_q <= seq_err_d;
		end
	end

	assign RSP_VALID = rsp_valid_q;
	assign RSP_HIT = rsp_hit_q;
	assign RSP_MISS = rsp_miss_q;
	assign RSP_RDATA = rsp_rdata_q;
	assign RSP_WAY = rsp_way_q;
	assign FILL_REQ = fill_req_q;
	assign FILL_PADDR = miss_pa_q;
	assign ICACHE_INV = inv_q;
	assign ICACHE_INV_PADDR = inv_pa_q;
	assign PIPE_FLUSH = flush_q;
	assign FETCH_RESTART_PADDR = restart_q;
	assign FETCH_SEQ_ERR = seq_err_q;

	a_hit_miss_excl: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_05]
		!(RSP_HIT && RSP_MISS))
		else $error("hit and miss together");
	a_hit_response: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_04]
		(REQ_VALID && fsm_q == sac_pkg::SAC_IDLE && hit)
		|=> (RSP_HIT && RSP_WAY == $past(hit_way)))
		else $error("hit not reported");
	a_miss_response: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_05]
		(REQ_VALID && fsm_q == sac_pkg::SAC_IDLE && !hit) |=> RSP_MISS)
		else $error("miss not reported");
	a_store_inval: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_08]
		(REQ_VALID && REQ_WRITE && fsm_q == sac_pkg::SAC_IDLE)
		|=> (ICACHE_INV && ICACHE_INV_PADDR == $past(REQ_PADDR)))
		else $error("store did not invalidate icache");
	a_smc_flush: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_09]
		(REQ_VALID && REQ_WRITE && fsm_q == sac_pkg::SAC_IDLE && |infl_hit) |=> PIPE_FLUSH)
		else $error("no flush on in-flight overwrite");
	a_flush_cause: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_10]
		PIPE_FLUSH |-> $past(REQ_WRITE && |infl_hit))
		else $error("spurious flush");
	a_fill_done: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_18]
		(fsm_q == sac_pkg::SAC_FILL && FILL_VALID) |=> (fsm_q == sac_pkg::SAC_IDLE && !FILL_REQ))
		else $error("fill did not complete");
	a_fill_req_miss: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_18]
		$rose(FILL_REQ) |-> $past(REQ_CACHEABLE && !hit))
		else $error("fill without miss");
	a_seq_check: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE_13]
		FETCH_SEQ_ERR |-> $past(FETCH_VALID && !FETCH_BRANCH))
		else $error("bad seq flag");

	c_read_hit: cover property (@(posedge CLK_SYS) disable iff (RST) RSP_HIT && !$past(REQ_WRITE));
	c_miss_fill: cover property (@(posedge CLK_SYS) disable iff (RST) FILL_REQ ##[1:20] !FILL_REQ);
	c_smc_flush: cover property (@(posedge CLK_SYS) disable iff (RST) PIPE_FLUSH);
	c_store_hit: cover property (@(posedge CLK_SYS) disable iff (RST) ICACHE_INV && RSP_HIT);
endmodule

// ### verilog/sac_pkg.sv
// sac_pkg: shared sizes, field positions and encodings for the set-associative cache
// assumes a single core clock and physical addresses from the pipeline
package sac_pkg;
	localparam int PA_W     = 32;
	localparam int OFF_W    = 4;
	localparam int IDX_W    = 4;
	localparam int TAG_W    = PA_W - OFF_W - IDX_W;
	localparam int OFF_LSB  = 0;
	localparam int IDX_LSB  = OFF_W;
	localparam int TAG_LSB  = OFF_W + IDX_W;
	localparam int WAYS     = 4;
	localparam int WAY_W    = 2;
	localparam int SETS     = 16;
	localparam int LINE_B   = 16;
	localparam int LINE_W   = LINE_B * 8;
	localparam int QW_W     = 64;
	localparam int INFL     = 4;
	localparam logic [1:0] RR_RST = 2'h0;
	typedef enum logic [2:0] {
		SAC_INV = 3'h0,
		SAC_SHR = 3'h1,
		SAC_EXC = 3'h2,
		SAC_OWN = 3'h3,
		SAC_MOD = 3'h4
	} sac_moesi_t;
	typedef enum logic [1:0] {SAC_IDLE, SAC_FILL} sac_state_t;
endpackage

// ### test/sac_mem_model.sv
// sac_mem_model: memory side that answers line fills after a short or long wait
// assumes fill requests are levels held until the fill edge
`timescale 1ns/10ps
module sac_mem_model (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         slow,
	input  wire logic         fill_req,
	input  wire logic [31:0]  fill_paddr,
	output logic              fill_valid,
	output logic [127:0]      fill_data
);
	logic [2:0]  cnt_q;
	logic [31:0] w;
	logic [127:0] pat;

	assign w = {fill_paddr[31:4], 4'h0} ^ 32'h5a5a5a5a;
	assign pat = {w + 32'h3, w + 32'h2, w + 32'h1, w};
	// inverted outside a fill so stale data can never pass for a line
	assign fill_data = fill_valid ? pat : ~pat;

	always_ff @(posedge clk_sys) begin
		if (rst || !fill_req || fill_valid) begin
			cnt_q      <= slow ? 3'h5 : 3'h0;
			fill_valid <= 1'b0;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end else begin
			fill_valid <= 1'b1;
		end
	end
endmodule

// ### test/tb_top.sv
// tb_top: directed and random accesses checked against a reference cache
// assumes the victim pointer moves past the way last filled or hit
`timescale 1ns/10ps
module tb_top;
	logic         clk, rst, rv, rw, rc, fv, fb, slow, mis, wr, ca;
	logic [31:0]  ra, fpa, ar;
	logic [63:0]  wd, dd;
	logic         iv [4];
	logic [31:0]  ia [4];
	logic         fill_v, o_v, o_h, o_m, o_fr, o_inv, o_fl, o_se;
	logic [127:0] fill_d;
	logic [63:0]  o_rd;
	logic [1:0]   o_w;
	logic [31:0]  o_fa, o_ia, o_ra;
	logic [23:0]  r_tag [16][4];
	logic         r_v   [16][4];
	logic [127:0] r_dat [16][4];
	logic [1:0]   r_rr  [16];
	int           fails, n_checks, seed, i;

	sac_cache sac_cache_inst (.CLK_SYS(clk), .RST(rst), .REQ_VALID(rv), .REQ_WRITE(rw),
		.REQ_CACHEABLE(rc), .REQ_PADDR(ra), .REQ_WDATA(wd), .FILL_VALID(fill_v),
		.FILL_DATA(fill_d), .INFL_VALID_0(iv[0]), .INFL_PADDR_0(ia[0]),
		.INFL_VALID_1(iv[1]), .INFL_PADDR_1(ia[1]), .INFL_VALID_2(iv[2]),
		.INFL_PADDR_2(ia[2]), .INFL_VALID_3(iv[3]), .INFL_PADDR_3(ia[3]),
		.FETCH_VALID(fv), .FETCH_BRANCH(fb), .FETCH_PADDR(fpa), .RSP_VALID(o_v),
		.RSP_HIT(o_h), .RSP_MISS(o_m), .RSP_RDATA(o_rd), .RSP_WAY(o_w),
		.FILL_REQ(o_fr), .FILL_PADDR(o_fa), .ICACHE_INV(o_inv), .ICACHE_INV_PADDR(o_ia),
		.PIPE_FLUSH(o_fl), .FETCH_RESTART_PADDR(o_ra), .FETCH_SEQ_ERR(o_se));
	sac_mem_model sac_mem_model_inst (.clk_sys(clk), .rst(rst), .slow(slow),
		.fill_req(o_fr), .fill_paddr(o_fa), .fill_valid(fill_v), .fill_data(fill_d));

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	task automatic stop_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [127:0] pat(input logic [31:0] a);
		logic [31:0] w;
		w = {a[31:4], 4'h0} ^ 32'h5a5a5a5a;
		return {w + 32'h3, w + 32'h2, w + 32'h1, w};
	endfunction

	task automatic clr;
		for (int s = 0; s < 16; s++) begin
			r_rr[s] = 0;
			for (int k = 0; k < 4; k++) begin
				r_v[s][k] = 0;
				iv[k] = 0;
				ia[k] = 0;
			end
		end
	endtask

	// request held high through a fill so the retry follows the fill edge
	task automatic acc(input logic w, input logic c, input logic [31:0] a, input logic [63:0] d);
		int s, h, k;
		logic f;
		logic [127:0] ln;
		rv = 1;
		rw = w;
		rc = c;
		ra = a;
		wd = d;
		s = a[7:4];
		do begin
			h = -1;
			f = 0;
			for (k = 0; k < 4; k++) begin
				if (r_v[s][k] && r_tag[s][k] == a[31:8]) h = k;
				if (iv[k] && ia[k][31:3] == a[31:3]) f = 1;
			end
			@(posedge clk);
			#1;
			chk(o_v, 1);
			chk(o_h, h >= 0);
			chk(o_m, h < 0);
			if (w) begin
				chk(o_inv, 1);
				chk(o_ia, a);
				chk(o_fl, f);
				if (f) chk(o_ra, {a[31:3], 3'h0});
			end else begin
				chk(o_inv, 0);
				chk(o_fl, 0);
			end
			mis = h < 0 && c;
			if (h >= 0) begin
				chk(o_w, h);
				r_rr[s] = 2'(h + 1);
				ln = r_dat[s][h];
				for (k = 0; k < 8; k++)
					if (w && a[3:0] + k < 16) ln[(a[3:0] + k) * 8 +: 8] = d[k * 8 +: 8];
				r_dat[s][h] = ln;
				ln = ln >> (a[3:0] * 8);
				if (!w) chk(o_rd, ln[63:0]);
			end else if (c) begin
				chk(o_fr, 1);
				chk(o_fa, a);
				for (k = 0; k < 60 && o_fr !== 1'b0; k++) begin
					@(posedge clk);
					#1;
					chk(o_v, 0);
				end
				chk(k < 60, 1);
				k = r_rr[s];
				r_v[s][k] = 1;
				r_tag[s][k] = a[31:8];
				r_dat[s][k] = pat(a);
				r_rr[s] = 2'(k + 1);
			end else begin
				chk(o_fr, 0);
			end
		end while (mis);
	endtask

	task automatic fch(input logic b, input logic [31:0] a, input logic e);
		fv = 1;
		fb = b;
		fpa = a;
		@(posedge clk);
		#1;
		chk(o_se, e);
	endtask

	initial begin
		#400000;
		fails++;
		stop_test();
	end

	initial begin
		seed = 80053;
		{rst, rv, rw, rc, fv, fb, slow} = 7'h40;
		ra = 0;
		wd = 0;
		fpa = 0;
		clr();
		repeat (6) @(posedge clk);
		#1 rst = 0;
		acc(0, 1, 32'h1230, 0);
		iv[0] = 1;
		ia[0] = 32'h123c;
		acc(1, 1, 32'h1238, 64'h0123456789abcdef);
		acc(0, 1, 32'h1238, 0);
		acc(0, 0, 32'h5670, 0);
		rv = 0;
		fch(1, 32'h1238, 0);
		fch(1, 32'h100, 0);
		fch(0, 32'h108, 0);
		fch(0, 32'h108, 1);
		fch(1, 32'h40, 0);
		fch(0, 32'h38, 1);
		fv = 0;
		for (i = 0; i < 400; i++) begin
			for (int k = 0; k < 4; k++) begin
				iv[k] = 1'($random(seed));
				ia[k] = $random(seed);
			end
			wr = 1'($random(seed));
			ca = ($random(seed) & 7) != 0;
			dd = {$random(seed), $random(seed)};
			slow = 1'($random(seed));
			ar = {21'h1, 3'($random(seed)), 2'h0, 2'($random(seed)), 4'h0};
			ar[3:0] = wr ? {1'b1 & 1'($random(seed)), 3'h0} : 4'(3'($random(seed)));
			if (wr) ia[1] = ar ^ 32'h5;
			acc(wr, ca, ar, dd);
		end
		rv = 0;
		rst = 1;
		repeat (2) @(posedge clk);
		#1 rst = 0;
		clr();
		chk(o_fr, 0);
		acc(0, 1, 32'h1230, 0);
		rv = 0;
		stop_test();
	end
endmodule
